// >>> design/microcore_config_instr_decode.sv
// decoder and executor of four microcore configuration instructions
// assumes the sequencer gives one instruction per valid cycle and the
// shortcut logic supplies the first shortcut as a stable index
`timescale 1ns/1ps
// Functional notes
// - word mode returns all sixteen bits
// - low mode: low byte, upper zero
// - high mode: high byte down, upper zero
// - swap mode exchanges the two bytes
// - mode holds for later loads until changed
// - read mode resets to word
// - end-of-actuation only touches permitted high-sides
// - mask forces threshold 000, else config
// - switch: keep, on, neutral, forced off
// - defaults: no mask, bootstrap forced off
// - set-flag writes one bit only
// - selector value n picks flag n
// - freewheel operand: 0 manual, 1 automatic
// - freewheel driver follows first shortcut map
// - first shortcut comes from outside input
// - freewheel change needs drive right
// - freewheel resets to manual
module microcore_config_instr_decode (
  input wire logic sys_clk,
  input wire logic rst_n,
  input microcore_cfg_pkg::apb_req_t apbReq,
  output microcore_cfg_pkg::apb_rsp_t apbRsp,
  input microcore_cfg_pkg::instr_t instr,
  input wire logic [2:0] firstShortcut,
  input wire logic loadReq,
  input wire logic [5:0] loadAddr,
  input wire logic storeReq,
  input wire logic [5:0] storeAddr,
  input wire logic [15:0] storeData,
  output logic loadValid,
  output logic [15:0] loadData,
  output logic [15:0] flags,
  output logic [1:0] readMode,
  output logic fwAuto,
  output logic [3:0] fwOut,
  output logic [14:0] hsThreshold,
  output logic [4:0] bsForceOff,
  output logic [4:0] bsAllowOn
);
  microcore_cfg_pkg::core_state_t st; // registered state
  microcore_cfg_pkg::core_state_t next_st; // next state
  logic [15:0] memData; // raw line from the data ram
  logic wordIdxOk; // apb address is word aligned
  logic [9:0] wordIdx; // register index of the access

  // format a raw data ram line according to the read mode
  function automatic logic [15:0] formatRead(input logic [1:0] mode, input logic [15:0] line);
    logic [15:0] res;
    res = line;
    if (mode == microcore_cfg_pkg::RD_LOW) begin
      res = {8'h00, line[7:0]};
    end else if (mode == microcore_cfg_pkg::RD_HIGH) begin
      res = {8'h00, line[15:8]};
    end else if (mode == microcore_cfg_pkg::RD_SWAP) begin
      res = {line[7:0], line[15:8]};
    end
    return res;
  endfunction

  // threshold selection of every high-side from mask bits and configuration
  function automatic logic [14:0] thresholds(input logic [4:0] mask, input logic [14:0] cfg);
    logic [14:0] res;
    res = cfg;
    for (int i = 0; i < microcore_cfg_pkg::NUM_HS; i++) begin
      if (mask[i]) begin
        res[3*i +: 3] = 3'h0;
      end
    end
    return res;
  endfunction

  // freewheel pre-driver picked by the first shortcut high-side
  function automatic logic [3:0] freewheelOut(input logic [2:0] sc);
    logic [3:0] res;
    case (sc)
      3'h0: res = microcore_cfg_pkg::OUT_LS5;
      3'h1: res = microcore_cfg_pkg::OUT_LS6;
      3'h2: res = microcore_cfg_pkg::OUT_LS7;
      3'h3: res = microcore_cfg_pkg::OUT_HS5;
      3'h4: res = microcore_cfg_pkg::OUT_LS4;
      default: res = microcore_cfg_pkg::OUT_UNDEF;
    endcase
    return res;
  endfunction

  // the data ram itself; loads read it, stores write it
  dram_mem dram (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wrEn(storeReq),
    .wrAddr(storeAddr),
    .wrData(storeData),
    .rdEn(loadReq),
    .rdAddr(loadAddr),
    .rdData(memData)
  );

  assign wordIdx = apbReq.paddr[11:2];
  assign wordIdxOk = (apbReq.paddr[1:0] == 2'h0);

  // next state: instruction execution, load formatting and apb slave
  always_comb begin
    logic [1:0] sw;
    logic [3:0] fwTarget;
    logic apbDone;
    sw = 2'h0;
    fwTarget = 4'h0;
    apbDone = 1'b0;
    next_st = st;
    // load pipeline: mode is captured with the request so a mode change in
    // the same cycle only governs later loads
    next_st.ldPend = loadReq;
    next_st.ldValid = st.ldPend;
    if (loadReq) begin
      next_st.ldMode = st.readMode;
    end
    if (st.ldPend) begin
      next_st.ldData = formatRead(st.ldMode, memData);
    end
    // freewheel target follows the shortcut logic continuously
    fwTarget = freewheelOut(firstShortcut);
    next_st.fwOut = fwTarget;
    if (instr.valid) begin
      if (instr.word[15:2] == microcore_cfg_pkg::OP_READ_MODE) begin
        next_st.readMode = instr.word[1:0];
      end else if (instr.word[15:3] == microcore_cfg_pkg::OP_END_ACT) begin
        sw = instr.word[1:0];
        for (int i = 0; i < microcore_cfg_pkg::NUM_HS; i++) begin
          // only high-sides this core may drive are touched
          if (st.access[i]) begin
            next_st.thrMask[i] = instr.word[2];
            if (sw != microcore_cfg_pkg::SW_KEEP) begin
              next_st.bsCode[2*i +: 2] = sw;
            end
          end
        end
      end else if (instr.word[15:5] == microcore_cfg_pkg::OP_SET_FLAG) begin
        next_st.flags[instr.word[3:0]] = instr.word[4];
      end else if (instr.word[15:1] == microcore_cfg_pkg::OP_FREEWHEEL) begin
        // an unmapped shortcut names no output, so no right can be held
        if (fwTarget != microcore_cfg_pkg::OUT_UNDEF && st.access[fwTarget]) begin
          next_st.fwAuto = instr.word[0];
        end
      end
    end
    // apb: ready one cycle into the access phase, then drop
    next_st.rsp.pready = apbReq.psel && apbReq.penable && !st.rsp.pready;
    apbDone = apbReq.psel && apbReq.penable && st.rsp.pready;
    if (apbReq.psel && apbReq.penable && !st.rsp.pready) begin
      next_st.rsp.pslverr = 1'b0;
      next_st.rsp.prdata = 32'h0000_0000;
      if (!wordIdxOk) begin
        next_st.rsp.pslverr = 1'b1;
      end else if (wordIdx == microcore_cfg_pkg::IDX_ACCESS) begin
        next_st.rsp.prdata = {20'h00000, st.access};
      end else if (wordIdx == microcore_cfg_pkg::IDX_THRESH) begin
        next_st.rsp.prdata = {17'h00000, st.thrCfg};
      end else if (wordIdx == microcore_cfg_pkg::IDX_MODES) begin
        next_st.rsp.prdata[microcore_cfg_pkg::MODES_READ_LSB +: 2] = st.readMode;
        next_st.rsp.prdata[microcore_cfg_pkg::MODES_FW_BIT] = st.fwAuto;
        next_st.rsp.prdata[microcore_cfg_pkg::MODES_MASK_LSB +: 5] = st.thrMask;
        next_st.rsp.prdata[microcore_cfg_pkg::MODES_BS_LSB +: 10] = st.bsCode;
      end else if (wordIdx == microcore_cfg_pkg::IDX_FLAGS) begin
        next_st.rsp.prdata = {16'h0000, st.flags};
      end else begin
        next_st.rsp.pslverr = 1'b1; // unmapped address
      end
    end
    // writes land at the completing edge only; status words are read-only
    if (apbDone && apbReq.pwrite && wordIdxOk) begin
      if (wordIdx == microcore_cfg_pkg::IDX_ACCESS) begin
        next_st.access = apbReq.pwdata[11:0];
      end else if (wordIdx == microcore_cfg_pkg::IDX_THRESH) begin
        next_st.thrCfg = apbReq.pwdata[14:0];
      end
    end
    // derived outputs are computed from next values so they stay in step
    next_st.hsThr = thresholds(next_st.thrMask, next_st.thrCfg);
    for (int i = 0; i < microcore_cfg_pkg::NUM_HS; i++) begin
      next_st.bsOff[i] = next_st.bsCode[2*i +: 2] == microcore_cfg_pkg::SW_BS_OFF;
      next_st.bsOn[i] = next_st.bsCode[2*i +: 2] == microcore_cfg_pkg::SW_BS_ON;
    end
  end

  // state register with documented reset defaults
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.readMode <= microcore_cfg_pkg::RST_READ_MODE;
      st.thrMask <= 5'h00;
      st.bsCode <= {5{microcore_cfg_pkg::RST_BS_CODE}};
      st.bsOff <= 5'h1f;
      st.fwAuto <= microcore_cfg_pkg::RST_FW_AUTO;
      st.access <= microcore_cfg_pkg::RST_ACCESS;
      st.thrCfg <= microcore_cfg_pkg::RST_THRESH;
      st.fwOut <= microcore_cfg_pkg::OUT_LS5;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign apbRsp = st.rsp;
  assign loadValid = st.ldValid;
  assign loadData = st.ldData;
  assign flags = st.flags;
  assign readMode = st.readMode;
  assign fwAuto = st.fwAuto;
  assign fwOut = st.fwOut;
  assign hsThreshold = st.hsThr;
  assign bsForceOff = st.bsOff;
  assign bsAllowOn = st.bsOn;

  // helper: opcode hits
  logic isRead;
  logic isEoa;
  logic isFlag;
  logic isFw;
  assign isRead = instr.valid && instr.word[15:2] == microcore_cfg_pkg::OP_READ_MODE;
  assign isEoa = instr.valid && instr.word[15:3] == microcore_cfg_pkg::OP_END_ACT;
  assign isFlag = instr.valid && instr.word[15:5] == microcore_cfg_pkg::OP_SET_FLAG;
  assign isFw = instr.valid && instr.word[15:1] == microcore_cfg_pkg::OP_FREEWHEEL;

  a_load_word_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (loadReq && readMode == 2'h0) |-> ##2 (loadValid && loadData == $past(memData)))
    else $error("word mode load altered data");
  a_load_low_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (loadReq && readMode == 2'h1) |-> ##2 (loadData == {8'h00, $past(memData[7:0])}))
    else $error("low byte load wrong");
  a_load_high_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (loadReq && readMode == 2'h2) |-> ##2 (loadData == {8'h00, $past(memData[15:8])}))
    else $error("high byte load wrong");
  a_load_swap_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (loadReq && readMode == 2'h3) |-> ##2
      (loadData == {$past(memData[7:0]), $past(memData[15:8])}))
    else $error("swap load wrong");
  a_read_mode_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    isRead |=> (readMode == $past(instr.word[1:0])) ##1 (!$changed(readMode) || $past(isRead)))
    else $error("read mode not held");
  a_eoa_permitted: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (isEoa && !st.access[0]) |=> $stable(bsForceOff[0]) && ($stable(hsThreshold[2:0])
      || $past(st.thrCfg[2:0]) != st.thrCfg[2:0]))
    else $error("forbidden high-side changed");
  a_thr_masked: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (isEoa && instr.word[2] && st.access[1]) |=> (hsThreshold[5:3] == 3'h0))
    else $error("masked threshold not zero");
  a_bs_forced_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (isEoa && instr.word[1:0] == 2'h3 && st.access[0]) |=> (bsForceOff[0] && !bsAllowOn[0]))
    else $error("bootstrap not forced off");
  a_flag_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
    isFlag |=> (flags[$past(instr.word[3:0])] == $past(instr.word[4])) &&
      ((flags ^ $past(flags)) & ~(16'h0001 << $past(instr.word[3:0]))) == 16'h0000)
    else $error("flag write wrong");
  a_fw_rights: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (isFw && $stable(firstShortcut) && fwOut != 4'hc && !st.access[fwOut]) |=> $stable(fwAuto))
    else $error("freewheel changed without right");
  a_fw_map: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (firstShortcut == 3'h0) |=> (fwOut == 4'h9))
    else $error("freewheel map wrong");
endmodule

// >>> design/microcore_cfg_pkg.sv
// constants, field layouts and carrier types of the microcore configuration decoder
// assumes one 50 MHz clock and an apb master with 32-bit data
package microcore_cfg_pkg;
  // instruction opcode patterns, matched on the bits above each operand
  localparam logic [13:0] OP_READ_MODE = 14'h0d60; // 0011_0101_1000_00 + mode(2)
  localparam logic [12:0] OP_END_ACT = 13'h06a4; // 0011_0101_0010_0 + mask + switch(2)
  localparam logic [10:0] OP_SET_FLAG = 11'h1a7; // 0011_0100_111 + logic + selector(4)
  localparam logic [14:0] OP_FREEWHEEL = 15'h1ac8; // 0011_0101_1001_000 + mode
  // data ram read modes
  localparam logic [1:0] RD_WORD = 2'h0;
  localparam logic [1:0] RD_LOW = 2'h1;
  localparam logic [1:0] RD_HIGH = 2'h2;
  localparam logic [1:0] RD_SWAP = 2'h3;
  // end of actuation switch operand codes
  localparam logic [1:0] SW_KEEP = 2'h0;
  localparam logic [1:0] SW_BS_ON = 2'h1;
  localparam logic [1:0] SW_NEUTRAL = 2'h2;
  localparam logic [1:0] SW_BS_OFF = 2'h3;
  // pre-driver numbering, high-side 1..5 then low-side 1..7
  localparam logic [3:0] OUT_HS5 = 4'h4;
  localparam logic [3:0] OUT_LS4 = 4'h8;
  localparam logic [3:0] OUT_LS5 = 4'h9;
  localparam logic [3:0] OUT_LS6 = 4'ha;
  localparam logic [3:0] OUT_LS7 = 4'hb;
  localparam logic [3:0] OUT_UNDEF = 4'hc;
  localparam int NUM_HS = 5;
  localparam int NUM_OUT = 12;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_ACCESS = 10'h184;
  localparam logic [9:0] IDX_THRESH = 10'h18b;
  localparam logic [9:0] IDX_MODES = 10'h190;
  localparam logic [9:0] IDX_FLAGS = 10'h191;
  // reset values
  localparam logic [1:0] RST_READ_MODE = RD_WORD;
  localparam logic [1:0] RST_BS_CODE = SW_BS_OFF;
  localparam logic RST_FW_AUTO = 1'b0;
  localparam logic [11:0] RST_ACCESS = 12'h000;
  localparam logic [14:0] RST_THRESH = 15'h0000;
  // fields of the mode status word
  localparam int MODES_READ_LSB = 0;
  localparam int MODES_FW_BIT = 2;
  localparam int MODES_MASK_LSB = 3;
  localparam int MODES_BS_LSB = 8;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } instr_t;

  typedef struct packed {
    logic [1:0] readMode;
    logic [4:0] thrMask;
    logic [9:0] bsCode;
    logic [15:0] flags;
    logic fwAuto;
    logic [11:0] access;
    logic [14:0] thrCfg;
    logic ldPend;
    logic [1:0] ldMode;
    logic ldValid;
    logic [15:0] ldData;
    logic [14:0] hsThr;
    logic [3:0] fwOut;
    logic [4:0] bsOff;
    logic [4:0] bsOn;
    apb_rsp_t rsp;
  } core_state_t;
endpackage

// >>> design/dram_mem.sv
// data ram of 64 sixteen-bit lines with a registered read port
// assumes one writer and one reader on the same clock
`timescale 1ns/1ps
module dram_mem (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [5:0] wrAddr,
  input wire logic [15:0] wrData,
  input wire logic rdEn,
  input wire logic [5:0] rdAddr,
  output logic [15:0] rdData
);
  logic [15:0] lines [64]; // storage, not reset: contents are software's concern

  // write port
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      lines[wrAddr] <= wrData;
    end
  end

  // read data come out of a register, one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 16'h0000;
    end else if (rdEn) begin
      rdData <= lines[rdAddr];
    end
  end
endmodule

// >>> design/dummy_unused.sv
`timescale 1ns/1ps

// >>> testbench/seq_model.sv
// sequencer and shortcut stand-in feeding the configuration decoder
// assumes the bench changes issue and code just after a rising edge
`timescale 1ns/1ps
module seq_model (
  input wire logic issue,
  input wire logic [15:0] code,
  input wire logic [2:0] shortcutSel,
  output microcore_cfg_pkg::instr_t instr,
  output logic [2:0] firstShortcut
);
  // strobe passes straight through, one instruction per valid cycle
  assign instr.valid = issue;
  // idle word is the inverse of the last one so a decode leak shows up
  assign instr.word = issue ? code : ~code;
  // shortcut comes from the shortcut definition side, never from the freewheel op
  assign firstShortcut = shortcutSel;
endmodule

// >>> testbench/tb_top.sv
// self-checking bench of the configuration decoder
// assumes the apb slave answers on its own time and the bench waits for pready
`timescale 1ns/1ps
module tb_top;
  logic sys_clk; // 50 MHz system clock
  logic rst_n; // active low reset
  microcore_cfg_pkg::apb_req_t req; // apb request
  microcore_cfg_pkg::apb_rsp_t rsp; // apb answer
  microcore_cfg_pkg::instr_t instr; // from the sequencer model
  logic issue, storeReq, loadReq, loadValid, fwAuto;
  logic [15:0] code, storeData, loadData, flags;
  logic [2:0] shortcutSel, firstShortcut;
  logic [5:0] loadAddr, storeAddr;
  logic [1:0] readMode;
  logic [3:0] fwOut;
  logic [14:0] hsThreshold;
  logic [4:0] bsForceOff, bsAllowOn;
  logic [31:0] rd, expd;
  int fail_count, comparisons;
  int cyc = 0; // cycles since start, only the hang guard writes it
  logic [3:0] fwMap [5] = '{4'h9, 4'ha, 4'hb, 4'h4, 4'h8}; // freewheel per shortcut

  seq_model i_seq_model (.issue(issue), .code(code), .shortcutSel(shortcutSel),
    .instr(instr), .firstShortcut(firstShortcut));
  microcore_config_instr_decode i_microcore_config_instr_decode (.sys_clk(sys_clk),
    .rst_n(rst_n), .apbReq(req), .apbRsp(rsp), .instr(instr),
    .firstShortcut(firstShortcut), .loadReq(loadReq), .loadAddr(loadAddr),
    .storeReq(storeReq), .storeAddr(storeAddr), .storeData(storeData),
    .loadValid(loadValid), .loadData(loadData), .flags(flags), .readMode(readMode),
    .fwAuto(fwAuto), .fwOut(fwOut), .hsThreshold(hsThreshold),
    .bsForceOff(bsForceOff), .bsAllowOn(bsAllowOn));

  // clock source
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // report counts and verdict, then stop
  task give_verdict();
    $display("checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard, far above the hundred or so cycles the run needs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      give_verdict();
    end
  end

  // value compare; case equality so unknowns never match
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer: setup, access, hold until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req.psel <= 1'b1;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do @(posedge sys_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // one instruction strobe; outputs are settled when the task returns
  task exec(input logic [15:0] w);
    @(posedge sys_clk);
    issue <= 1'b1;
    code <= w;
    @(posedge sys_clk);
    issue <= 1'b0;
    #1;
  endtask

  // data ram load, waits a bounded time for the formatted answer
  task load(input logic [5:0] a);
    @(posedge sys_clk);
    loadReq <= 1'b1;
    loadAddr <= a;
    @(posedge sys_clk);
    loadReq <= 1'b0;
    repeat (4) begin
      @(posedge sys_clk);
      #1;
      if (loadValid === 1'b1) break;
    end
    // a missing answer would leave stale data that could still match
    chk("loadValid", 32'h1, 32'(loadValid));
  endtask

  initial begin
    req = '0;
    {issue, code, storeReq, storeAddr, storeData, loadReq, loadAddr} = '0;
    shortcutSel = 3'h0;
    fail_count = 0;
    comparisons = 0;
    rst_n = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    // reset state of the modes
    chk("readMode", 32'h0, readMode);
    chk("fwAuto", 32'h0, fwAuto);
    chk("bsForceOff", 32'h1f, bsForceOff);
    chk("hsThreshold", 32'h0, hsThreshold);
    // registers, including a refused unmapped place
    apb(1'b1, 12'h610, 32'h00000fff);
    apb(1'b1, 12'h62c, 32'h00002c6d);
    apb(1'b0, 12'h62c, 32'h0);
    chk("threshold cfg", 32'h00002c6d, rd);
    apb(1'b0, 12'h700, 32'h0);
    chk("unmapped err", 32'h1, rsp.pslverr);
    // every read mode on one line, then a later load keeps the last mode
    @(posedge sys_clk);
    storeReq <= 1'b1;
    storeAddr <= 6'h3;
    storeData <= 16'hc3a5;
    @(posedge sys_clk);
    storeReq <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      exec(16'h3580 | 16'(m));
      chk("readMode", 32'(m), readMode);
      load(6'h3);
      case (m)
        0: expd = 32'hc3a5;
        1: expd = 32'h00a5;
        2: expd = 32'h00c3;
        default: expd = 32'ha5c3;
      endcase
      chk("loadData", expd, loadData);
    end
    load(6'h3);
    chk("loadData again", 32'ha5c3, loadData);
    // flag set at both ends of the selector, clear at the top end
    exec(16'h34ff);
    chk("flags", 32'h8000, flags);
    exec(16'h34f0);
    exec(16'h34f7);
    exec(16'h34ef);
    chk("flags", 32'h0081, flags);
    apb(1'b0, 12'h644, 32'h0);
    chk("flags reg", 32'h0081, rd);
    // end of actuation: mask with forced off, then unmask with allow on
    exec(16'h3527);
    chk("hsThreshold", 32'h0, hsThreshold);
    chk("bsForceOff", 32'h1f, bsForceOff);
    exec(16'h3521);
    chk("hsThreshold", 32'h2c6d, hsThreshold);
    chk("bsAllowOn", 32'h1f, bsAllowOn);
    exec(16'h3520);
    chk("bsAllowOn keep", 32'h1f, bsAllowOn);
    exec(16'h3522);
    chk("neutral", 32'h0, {bsAllowOn, bsForceOff});
    // only the first high-side is permitted now
    apb(1'b1, 12'h610, 32'h00000001);
    exec(16'h3527);
    chk("hsThreshold", 32'h2c68, hsThreshold);
    chk("bsForceOff", 32'h01, bsForceOff);
    // freewheel driver follows the first shortcut
    for (int s = 0; s < 5; s++) begin
      @(posedge sys_clk);
      shortcutSel <= 3'(s);
      @(posedge sys_clk);
      #1;
      chk("fwOut", 32'(fwMap[s]), fwOut);
    end
    // no right on the freewheel output: change ignored
    exec(16'h3591);
    chk("fwAuto", 32'h0, fwAuto);
    apb(1'b1, 12'h610, 32'h00000100);
    exec(16'h3591);
    chk("fwAuto", 32'h1, fwAuto);
    apb(1'b0, 12'h640, 32'h0);
    chk("modes fw bit", 32'h1, rd[2]);
    exec(16'h3590);
    chk("fwAuto", 32'h0, fwAuto);
    // no high-side permitted now: mask and forced off must leave all alone
    exec(16'h3527);
    chk("hsThreshold none", 32'h2c68, hsThreshold);
    chk("bsForceOff none", 32'h01, bsForceOff);
    give_verdict();
  end
endmodule
